// ---- hw/slcap_pkg.sv ----
`default_nettype none
package slcap_pkg;
	// Register map
	localparam logic [11:0] SLCAP_OFF_SLOT_CAP  = 12'h054;
	localparam logic [11:0] SLCAP_OFF_LOCK      = 12'h100;
	localparam logic [11:0] SLCAP_OFF_MSG_STAT  = 12'h104;
	// Field positions of the slot capabilities word
	localparam int SLCAP_HP_LSB   = 0;
	localparam int SLCAP_HP_MSB   = 6;
	localparam int SLCAP_PLV_LSB  = 7;
	localparam int SLCAP_PLV_MSB  = 14;
	localparam int SLCAP_PLS_LSB  = 15;
	localparam int SLCAP_PLS_MSB  = 16;
	localparam int SLCAP_ILK_BIT  = 17;
	localparam int SLCAP_NOCC_BIT = 18;
	// Values after reset
	localparam logic [7:0]  SLCAP_PLV_RST  = 8'h00;
	localparam logic [1:0]  SLCAP_PLS_RST  = 2'h0;
	localparam logic        SLCAP_ILK_RST  = 1'h0;
	localparam logic        SLCAP_LOCK_RST = 1'h1;
	localparam logic [31:0] SLCAP_ZERO     = 32'h0000_0000;
	// Power limit scale encodings
	typedef enum logic [1:0] {
		SLCAP_SCALE_1    = 2'h0,
		SLCAP_SCALE_0P1  = 2'h1,
		SLCAP_SCALE_0P01 = 2'h2,
		SLCAP_SCALE_0P001 = 2'h3
	} slcap_scale_e;
	// Message sender states
	typedef enum logic [1:0] {
		SLCAP_MS_IDLE = 2'b01,
		SLCAP_MS_SEND = 2'b10
	} slcap_msg_e;
endpackage : slcap_pkg
`default_nettype wire

// ---- hw/slcap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a level from outside the clock domain
module slcap_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_ff;
	logic nxt_meta;
	logic sync_ff;
	logic nxt_sync;

	// First flop feeds only the second
	always_comb begin
		nxt_meta = d_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign q_out = sync_ff;
endmodule : slcap_sync
`default_nettype wire

// ---- hw/slcap_msg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Holds a power limit message request until the transmit path accepts it
module slcap_msg (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       trigger,
	input  wire logic [7:0] plv,
	input  wire logic [1:0] pls,
	output logic            msg_valid,
	input  wire logic       msg_ready,
	output logic [7:0]      msg_value,
	output logic [1:0]      msg_scale,
	output logic            msg_pending
);
	slcap_pkg::slcap_msg_e state_ff;
	slcap_pkg::slcap_msg_e nxt_state;
	logic [7:0]            val_ff;
	logic [7:0]            nxt_val;
	logic [1:0]            scl_ff;
	logic [1:0]            nxt_scl;
	logic                  again_ff;
	logic                  nxt_again;

	// A trigger during a send is remembered so the newest values still go out
	always_comb begin
		nxt_state = state_ff;
		nxt_val   = val_ff;
		nxt_scl   = scl_ff;
		nxt_again = again_ff;
		case (state_ff)
			slcap_pkg::SLCAP_MS_IDLE: begin
				if (trigger || again_ff) begin
					nxt_state = slcap_pkg::SLCAP_MS_SEND;
					nxt_val   = plv;
					nxt_scl   = pls;
					nxt_again = 1'b0;
				end
			end
			slcap_pkg::SLCAP_MS_SEND: begin
				if (trigger)
					nxt_again = 1'b1;
				if (msg_ready)
					nxt_state = slcap_pkg::SLCAP_MS_IDLE;
			end
			default: nxt_state = slcap_pkg::SLCAP_MS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= slcap_pkg::SLCAP_MS_IDLE;
			val_ff   <= slcap_pkg::SLCAP_PLV_RST;
			scl_ff   <= slcap_pkg::SLCAP_PLS_RST;
			again_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			val_ff   <= nxt_val;
			scl_ff   <= nxt_scl;
			again_ff <= nxt_again;
		end
	end

	assign msg_valid   = (state_ff == slcap_pkg::SLCAP_MS_SEND);
	assign msg_value   = val_ff;
	assign msg_scale   = scl_ff;
	assign msg_pending = msg_valid | again_ff;
endmodule : slcap_msg
`default_nettype wire

// ---- hw/slcap_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Bits 0 to 6, the hot-plug presence and capability indications, always read zero and ignore writes.
// [RQ2] Bit 18, command-completed support, always reads zero and ignores writes.
// [RQ3] Bit 17, interlock present, is a lockable writable bit resetting to zero with no function behind it.
// [RQ4] Bits 14:7 hold a lockable eight-bit power limit magnitude resetting to zero.
// [RQ5] Bits 16:15 hold a lockable two-bit power limit scale resetting to zero, 0 to 3 meaning 1.0 down to 0.001.
// [RQ6] A power limit message with current magnitude and scale goes out on every register write and on link up.
// [RQ7] With the slot-implemented bit clear, magnitude and scale read zero and cannot be written.
// [RQ8] Lockable fields take writes only while the register lock is released.
module slcap_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        slot_implemented,
	input  wire logic        link_dl_up,
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic [7:0]       msg_value,
	output logic [1:0]       msg_scale
);
	logic [7:0]  plv_ff;
	logic [7:0]  nxt_plv;
	logic [1:0]  pls_ff;
	logic [1:0]  nxt_pls;
	logic        ilk_ff;
	logic        nxt_ilk;
	logic        lock_ff;
	logic        nxt_lock;
	logic        dlup_prev_ff;
	logic        nxt_dlup_prev;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        slot_s;
	logic        dlup_s;
	logic        acc;
	logic        wr_acc;
	logic        hit_cap;
	logic        hit_lock;
	logic        hit_stat;
	logic        trigger;
	logic        pending;
	logic        can_lock_wr;
	logic [31:0] cap_word;
	logic        first_ff;
	logic        nxt_first;

	// Pins from the port core come through synchronisers
	slcap_sync u_sync_slot (
		.pclk    (pclk),
		.presetn (presetn),
		.d_in    (slot_implemented),
		.q_out   (slot_s)
	);

	slcap_sync u_sync_dlup (
		.pclk    (pclk),
		.presetn (presetn),
		.d_in    (link_dl_up),
		.q_out   (dlup_s)
	);

	// Decode; zero wait states, so the access phase is the taking edge
	assign acc      = psel & penable;
	assign wr_acc   = acc & pwrite;
	assign hit_cap  = (paddr == slcap_pkg::SLCAP_OFF_SLOT_CAP);
	assign hit_lock = (paddr == slcap_pkg::SLCAP_OFF_LOCK);
	assign hit_stat = (paddr == slcap_pkg::SLCAP_OFF_MSG_STAT);
	assign pready   = 1'b1;
	assign pslverr  = acc & ~(hit_cap | hit_lock | hit_stat);

	// Lockable fields are writable only when unlocked
	assign can_lock_wr = wr_acc & hit_cap & ~lock_ff; // RQ8

	// Composed read value; hot-plug bits and bit 18 stay zero
	always_comb begin
		cap_word = slcap_pkg::SLCAP_ZERO; // RQ1
		cap_word[slcap_pkg::SLCAP_NOCC_BIT] = 1'b0; // RQ2
		cap_word[slcap_pkg::SLCAP_ILK_BIT] = ilk_ff; // RQ3
		if (slot_s) begin
			cap_word[slcap_pkg::SLCAP_PLV_MSB:slcap_pkg::SLCAP_PLV_LSB] = plv_ff; // RQ4
			cap_word[slcap_pkg::SLCAP_PLS_MSB:slcap_pkg::SLCAP_PLS_LSB] = pls_ff; // RQ5
		end
	end

	// Register state; the byte lanes gate each field
	always_comb begin
		nxt_plv  = plv_ff;
		nxt_pls  = pls_ff;
		nxt_ilk  = ilk_ff;
		nxt_lock = lock_ff;
		if (can_lock_wr && slot_s) begin // RQ7
			if (pstrb[0])
				nxt_plv[0] = pwdata[slcap_pkg::SLCAP_PLV_LSB];
			if (pstrb[1])
				nxt_plv[7:1] = pwdata[slcap_pkg::SLCAP_PLV_MSB:slcap_pkg::SLCAP_PLV_LSB + 1]; // RQ4
			if (pstrb[1])
				nxt_pls[0] = pwdata[slcap_pkg::SLCAP_PLS_LSB];
			if (pstrb[2])
				nxt_pls[1] = pwdata[slcap_pkg::SLCAP_PLS_MSB]; // RQ5
		end
		if (can_lock_wr && pstrb[2])
			nxt_ilk = pwdata[slcap_pkg::SLCAP_ILK_BIT]; // RQ3
		if (wr_acc && hit_lock && pstrb[0])
			nxt_lock = pwdata[0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			plv_ff  <= slcap_pkg::SLCAP_PLV_RST;
			pls_ff  <= slcap_pkg::SLCAP_PLS_RST;
			ilk_ff  <= slcap_pkg::SLCAP_ILK_RST;
			lock_ff <= slcap_pkg::SLCAP_LOCK_RST;
		end else begin
			plv_ff  <= nxt_plv;
			pls_ff  <= nxt_pls;
			ilk_ff  <= nxt_ilk;
			lock_ff <= nxt_lock;
		end
	end

	// Read data registered at the setup cycle so it is stable in the access phase
	always_comb begin
		nxt_rdata = rdata_ff;
		if (psel && !penable && !pwrite) begin
			if (paddr == slcap_pkg::SLCAP_OFF_SLOT_CAP)
				nxt_rdata = cap_word;
			else if (paddr == slcap_pkg::SLCAP_OFF_LOCK)
				nxt_rdata = {31'h0, lock_ff};
			else if (paddr == slcap_pkg::SLCAP_OFF_MSG_STAT)
				nxt_rdata = {30'h0, dlup_s, pending};
			else
				nxt_rdata = slcap_pkg::SLCAP_ZERO;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_ff <= slcap_pkg::SLCAP_ZERO;
		else
			rdata_ff <= nxt_rdata;
	end

	assign prdata = rdata_ff;

	// Link-up edge detect works on the synchronised level only
	always_comb begin
		nxt_dlup_prev = dlup_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dlup_prev_ff <= 1'b0;
		else
			dlup_prev_ff <= nxt_dlup_prev;
	end

	// Marks the first cycle out of reset so the reset values can be checked there
	always_comb begin
		nxt_first = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			first_ff <= 1'b1;
		else
			first_ff <= nxt_first;
	end

	// Any write to the register sends, even a locked one
	assign trigger = (wr_acc & hit_cap) | (dlup_s & ~dlup_prev_ff); // RQ6

	// Message values read zero when no slot is present, matching the register view
	slcap_msg u_msg (
		.pclk        (pclk),
		.presetn     (presetn),
		.trigger     (trigger),
		.plv         (slot_s ? nxt_plv : 8'h00),
		.pls         (slot_s ? nxt_pls : 2'h0),
		.msg_valid   (msg_valid),
		.msg_ready   (msg_ready),
		.msg_value   (msg_value),
		.msg_scale   (msg_scale),
		.msg_pending (pending)
	);

	a_hp_bits_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		cap_word[6:0] == 7'h00 && cap_word[31:19] == 13'h0000)
		else $error("hot-plug bits not zero");

	a_nocc_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		cap_word[18] == 1'b0)
		else $error("bit 18 not zero");

	a_ilk_locked_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		lock_ff |=> $stable(ilk_ff))
		else $error("interlock bit changed while locked");

	a_plv_write_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(can_lock_wr && slot_s && pstrb[1:0] == 2'h3) |=> plv_ff == $past(pwdata[14:7]))
		else $error("power value write lost");

	a_pls_write_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		(can_lock_wr && slot_s && pstrb[2:1] == 2'h3) |=> pls_ff == $past(pwdata[16:15]))
		else $error("power scale write lost");

	a_msg_on_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(wr_acc && hit_cap) |-> ##[1:3] msg_valid)
		else $error("no message after write");

	a_msg_on_linkup: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		$rose(dlup_s) |-> ##[1:3] msg_valid)
		else $error("no message after link up");

	a_noslot_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		!slot_s |-> cap_word[16:7] == 10'h000)
		else $error("power fields visible without slot");

	a_locked_no_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		lock_ff |=> ($stable(plv_ff) && $stable(pls_ff)))
		else $error("power field changed while locked");

	// Read path: the word loaded in the setup cycle is what leaves the bus
	a_rd_hp_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		(psel && !penable && !pwrite && hit_cap) |=> prdata[6:0] == 7'h00)
		else $error("hot-plug bits read back nonzero");

	a_rd_nocc_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		(psel && !penable && !pwrite && hit_cap) |=> prdata[18] == 1'b0)
		else $error("bit 18 read back nonzero");

	a_rd_noslot_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		(psel && !penable && !pwrite && hit_cap && !slot_s) |=> prdata[16:7] == 10'h000)
		else $error("power fields read back without slot");

	a_rd_lock_view: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		(psel && !penable && !pwrite && hit_lock) |=> prdata[0] == $past(lock_ff))
		else $error("lock bit read back wrong");

	// Values after reset, seen in the first cycle out of reset
	a_ilk_reset_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		first_ff |-> ilk_ff == slcap_pkg::SLCAP_ILK_RST)
		else $error("interlock bit not zero after reset");

	a_plv_reset_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		first_ff |-> plv_ff == slcap_pkg::SLCAP_PLV_RST)
		else $error("power value not zero after reset");

	a_pls_reset_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		first_ff |-> pls_ff == slcap_pkg::SLCAP_PLS_RST)
		else $error("power scale not zero after reset");

	a_lock_reset_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		first_ff |-> lock_ff == slcap_pkg::SLCAP_LOCK_RST)
		else $error("lock not set after reset");

	// Field writes and their byte lanes
	a_ilk_write_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(can_lock_wr && pstrb[2]) |=> ilk_ff == $past(pwdata[17]))
		else $error("interlock bit write lost");

	a_plv_lane_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(can_lock_wr && slot_s && !pstrb[1]) |=> plv_ff[7:1] == $past(plv_ff[7:1]))
		else $error("power value changed without its lane");

	a_pls_lane_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		(can_lock_wr && slot_s && !pstrb[2]) |=> pls_ff[1] == $past(pls_ff[1]))
		else $error("power scale changed without its lane");

	a_noslot_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		!slot_s |=> ($stable(plv_ff) && $stable(pls_ff)))
		else $error("power field written without slot");

	a_lock_wr_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		(wr_acc && hit_lock && pstrb[0]) |=> lock_ff == $past(pwdata[0]))
		else $error("lock write lost");

	// Message request towards the transmit path
	a_msg_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(msg_valid && !msg_ready) |=> (msg_valid && $stable(msg_value) && $stable(msg_scale)))
		else $error("message dropped or changed before acceptance");

	a_msg_write_value: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(wr_acc && hit_cap && !pending && slot_s) |=> (msg_value == plv_ff && msg_scale == pls_ff))
		else $error("message does not carry current limit");

	a_unmapped_no_msg: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(wr_acc && !hit_cap && !pending && !trigger) |=> !msg_valid)
		else $error("message without a trigger");

	a_msg_noslot_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		(trigger && !pending && !slot_s) |=> (msg_value == 8'h00 && msg_scale == 2'h0))
		else $error("message carries power fields without slot");
endmodule : slcap_top
`default_nettype wire

// ---- bench/slcap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fails++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench;
	logic        pclk             = 1'b0;
	logic        presetn          = 1'b0;
	logic        psel             = 1'b0;
	logic        penable          = 1'b0;
	logic        pwrite           = 1'b0;
	logic [11:0] paddr            = 12'h000;
	logic [31:0] pwdata           = 32'h0000_0000;
	logic [3:0]  pstrb            = 4'hf;
	logic        slot_implemented = 1'b1;
	logic        link_dl_up       = 1'b0;
	logic        msg_ready        = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        msg_valid;
	logic [7:0]  msg_value;
	logic [1:0]  msg_scale;
	logic [31:0] q;
	logic        e;
	logic [31:0] d;
	logic [7:0]  m_plv            = 8'h00;
	logic [1:0]  m_pls            = 2'h0;
	logic        m_ilk            = 1'b0;
	logic        m_lock           = 1'b1;
	integer      seed             = 97438;
	int          fails            = 0;
	int          comparisons      = 0;

	slcap_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slot_implemented(slot_implemented), .link_dl_up(link_dl_up),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .msg_value(msg_value), .msg_scale(msg_scale));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// Verdict and end of run; every bounded wait that runs out also lands here
	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test

	// Expected register word from the model; power fields vanish without a slot
	function automatic logic [31:0] exp_cap();
		logic [31:0] w;
		w = slcap_pkg::SLCAP_ZERO;
		w[slcap_pkg::SLCAP_ILK_BIT] = m_ilk;
		if (slot_implemented) begin
			w = w | (32'(m_plv) << slcap_pkg::SLCAP_PLV_LSB);
			w = w | (32'(m_pls) << slcap_pkg::SLCAP_PLS_LSB);
		end
		return w;
	endfunction : exp_cap

	// One APB transfer, entered just after a rising edge; an idle cycle follows
	// so psel is never assigned twice in one time step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			fails++;
			stop_test();
		end
		@(posedge pclk);
	endtask : apb

	// Wait for a message, stall the transmit side a while, then accept it
	task automatic msg_chk(input logic [7:0] v, input logic [1:0] s);
		int n;
		n = 0;
		while (msg_valid !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			fails++;
			stop_test();
		end
		repeat ($unsigned($random(seed)) % 4) @(posedge pclk);
		`CHK("msg_value", v, msg_value)
		`CHK("msg_scale", s, msg_scale)
		msg_ready <= 1'b1;
		@(posedge pclk);
		msg_ready <= 1'b0;
		@(posedge pclk);
		`CHK("msg_idle", 1'b0, msg_valid)
	endtask : msg_chk

	// Register write; the model only moves while unlocked, and only in enabled lanes
	task automatic wcap(input logic [31:0] wd);
		apb(1'b1, slcap_pkg::SLCAP_OFF_SLOT_CAP, wd);
		if (!m_lock) begin
			if (pstrb[2])
				m_ilk = wd[17];
			if (slot_implemented) begin
				if (pstrb[0])
					m_plv[0] = wd[7];
				if (pstrb[1]) begin
					m_plv[7:1] = wd[14:8];
					m_pls[0] = wd[15];
				end
				if (pstrb[2])
					m_pls[1] = wd[16];
			end
		end
		msg_chk(slot_implemented ? m_plv : 8'h00, slot_implemented ? m_pls : 2'h0);
	endtask : wcap

	task automatic rcap();
		apb(1'b0, slcap_pkg::SLCAP_OFF_SLOT_CAP, 32'h0000_0000);
		`CHK("slot_capabilities", exp_cap(), q)
	endtask : rcap

	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rcap();
		apb(1'b0, slcap_pkg::SLCAP_OFF_LOCK, 32'h0000_0000);
		`CHK("lock_reset", 1'b1, q[0])
		wcap(32'hffff_ffff);
		rcap();
		apb(1'b1, slcap_pkg::SLCAP_OFF_LOCK, 32'h0000_0000);
		m_lock = 1'b0;
		wcap(32'hffff_ffff);
		rcap();
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			pstrb <= (i < 6) ? 4'hf : 4'($random(seed)); // Partial lanes after the scale sweep
			if (i < 4) d[16:15] = i[1:0];
			wcap(d);
			rcap();
		end
		// Slot absent: power fields read zero and ignore writes
		pstrb <= 4'hf;
		slot_implemented <= 1'b0;
		repeat (3) @(posedge pclk);
		rcap();
		wcap($random(seed));
		rcap();
		slot_implemented <= 1'b1;
		repeat (3) @(posedge pclk);
		rcap();
		// Link reaching DL_Up sends the current limit
		link_dl_up <= 1'b1;
		msg_chk(m_plv, m_pls);
		// Unmapped word answers with an error and no message
		apb(1'b1, 12'h058, 32'hffff_ffff);
		`CHK("unmapped_err", 1'b1, e)
		apb(1'b0, 12'h058, 32'h0000_0000);
		`CHK("unmapped_rd", 32'h0000_0000, q)
		`CHK("no_msg", 1'b0, msg_valid)
		rcap();
		// Locked again: values hold but a message still goes out
		apb(1'b1, slcap_pkg::SLCAP_OFF_LOCK, 32'h0000_0001);
		m_lock = 1'b1;
		wcap(~exp_cap());
		rcap();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
